/* rtl/fdtf_defines.vh */
// Purpose: shared constants for the track format and control block
// Assumes: 32-bit AXI4-Lite register words, byte addresses below
// Notes:   register offsets, command, mode and interrupt codes, layout counts and CRC constants live here
`ifndef FDTF_DEFINES_VH
`define FDTF_DEFINES_VH
// ==========================================================
// Register byte offsets
`define FDTF_OFF_CTRL    8'h00
`define FDTF_OFF_CMD     8'h04
`define FDTF_OFF_FMT     8'h08
`define FDTF_OFF_CHRN    8'h0c
`define FDTF_OFF_STAT    8'h10
`define FDTF_OFF_RESULT  8'h14
`define FDTF_OFF_IRQ_ST  8'h18
`define FDTF_OFF_IRQ_MSK 8'h1c
// ==========================================================
// Command codes written to CMD
`define FDTF_CMD_FORMAT  3'h1
`define FDTF_CMD_READID  3'h2
`define FDTF_CMD_SENSE   3'h3
`define FDTF_CMD_SEEKEND 3'h4
`define FDTF_CMD_SEEKERR 3'h5
`define FDTF_CMD_OTHER   3'h6
// ==========================================================
// Recording modes in CTRL[1:0]
`define FDTF_MODE_MFM    2'h0
`define FDTF_MODE_FM     2'h1
`define FDTF_MODE_PERP   2'h2
// ==========================================================
// Interrupt codes and status bits
`define FDTF_IC_NORMAL   2'h0
`define FDTF_IC_ABNORMAL 2'h1
`define FDTF_IC_POLL     2'h3
`define FDTF_IRQ_DONE    0
`define FDTF_IRQ_SECT    1
// ==========================================================
// Track layout byte counts, CRC constants and byte timing
`define FDTF_MFM_GAP4A   8'd80
`define FDTF_MFM_SYNC    8'd12
`define FDTF_MFM_GAP1    8'd50
`define FDTF_MFM_GAP2    8'd22
`define FDTF_PERP_GAP2   8'd41
`define FDTF_FM_GAP4A    8'd40
`define FDTF_FM_SYNC     8'd6
`define FDTF_FM_GAP1     8'd26
`define FDTF_FM_GAP2     8'd11
`define FDTF_SECT_BASE   13'd128
`define FDTF_CRC_INIT    16'hffff
`define FDTF_CRC_POLY    16'h1021
`define FDTF_BYTE_NS     16000
`define FDTF_CLK_NS      10
`endif

/* rtl/fdtf_core.v */
// Purpose: track format writer and control command engine
// Assumes: byte stream toward the write path, id bytes from a decoder
// Notes:   one clock; registers over AXI4-Lite; no FIFO here
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fdtf_defines.vh"
module fdtf_core #(
  parameter BYTE_CYC = `FDTF_BYTE_NS / `FDTF_CLK_NS
) (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        index_pulse_in_n_i,
  input  wire        id_valid_i,
  input  wire [31:0] id_chrn_i,
  output reg  [7:0]  wr_byte_o,
  output reg         wr_strobe_o,
  output reg         wr_mark_o,
  output reg         wr_gate_o,
  output reg         irq_o
);
  // ==========================================================
  // Registers and state
  localparam S_IDLE = 4'd0, S_GAP = 4'd1, S_SYNC = 4'd2, S_PRE = 4'd3;
  localparam S_MARK = 4'd4, S_BODY = 4'd5, S_CRC = 4'd6, S_RID = 4'd7;
  localparam S_END = 4'd8;
  reg [3:0]  st_reg;
  reg [3:0]  fld_reg;    // Field index in track sequence
  reg [12:0] cnt_reg;
  reg [15:0] crc_reg;
  reg [15:0] tick_reg;
  reg [1:0]  mode_reg;
  reg        del_reg;
  reg [7:0]  sc_reg, gpl_reg, fill_reg, nsz_reg, sect_reg;
  reg [31:0] chrn_reg, res_reg;
  reg        chrn_ok_reg;
  reg [1:0]  ic_reg, pend_ic_reg;
  reg        se_reg, ma_reg, pend_reg, pend_se_reg, busy_reg;
  reg [1:0]  idx_seen_reg;
  reg [1:0]  ist_reg, imsk_reg;
  reg [2:0]  idx_sync_reg;
  reg        idx_prev_reg;
  reg        aw_hold_reg, w_hold_reg;
  reg [7:0]  aw_reg;
  reg [31:0] w_reg;
  wire       mfm = (mode_reg != `FDTF_MODE_FM);
  wire       idx_lvl = idx_sync_reg[2] | idx_sync_reg[1]; // Low once agreed
  wire       idx_pulse = ~idx_lvl & idx_prev_reg; // Falling index edge
  wire       tick = (tick_reg == 16'd0);
  wire       do_wr = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  reg        sect_evt_reg;  // One-cycle sector id consumed
  reg        done_evt_reg;  // One-cycle completion posted

  // CRC-CCITT byte step, MSB first
  function [15:0] crc8;
    input [15:0] c;
    input [7:0]  d;
    integer i;
    reg [15:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (r[15] ^ d[i])
          r = {r[14:0], 1'b0} ^ `FDTF_CRC_POLY;
        else
          r = {r[14:0], 1'b0};
      end
      crc8 = r;
    end
  endfunction

  // Gap byte by mode: 4e in MFM, ff in FM
  function [7:0] gapb;
    input m;
    begin
      gapb = m ? 8'h4e : 8'hff;
    end
  endfunction

  // ==========================================================
  // Index synchroniser, three stages, second and third agree
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      idx_sync_reg <= 3'h7;
      idx_prev_reg <= 1'b1;
    end else begin
      idx_sync_reg <= {idx_sync_reg[1:0], index_pulse_in_n_i};
      if (idx_sync_reg[2] == idx_sync_reg[1])
        idx_prev_reg <= idx_lvl;
    end
  end

  // ==========================================================
  // AXI4-Lite slave; write and address taken in either order
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_reg        <= 8'h0;
      w_reg         <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg   <= 1'b1;
        aw_reg        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg   <= 1'b1;
        w_reg        <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_reg > `FDTF_OFF_IRQ_MSK) ? 2'h2 : 2'h0;
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        case (s_axi_araddr)
          `FDTF_OFF_CTRL:    s_axi_rdata <= {29'h0, del_reg, mode_reg};
          `FDTF_OFF_FMT:
            s_axi_rdata <= {fill_reg, gpl_reg, sc_reg, nsz_reg};
          `FDTF_OFF_CHRN:    s_axi_rdata <= chrn_reg;
          `FDTF_OFF_STAT:
            s_axi_rdata <= {24'h0, chrn_ok_reg, pend_reg, busy_reg, ma_reg,
                            1'b0, se_reg, ic_reg};
          `FDTF_OFF_RESULT:  s_axi_rdata <= res_reg;
          `FDTF_OFF_IRQ_ST:  s_axi_rdata <= {30'h0, ist_reg};
          `FDTF_OFF_IRQ_MSK: s_axi_rdata <= {30'h0, imsk_reg};
          `FDTF_OFF_CMD:     s_axi_rdata <= 32'h0;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Command engine and format sequencer
  // Sequence fld: 0 gap4a,1 sync,2 iam,3 gap1, then per sector
  // 4 sync,5 sector_id_mark,6 chrn,7 crc,8 gap2,9 sync,10 dam,11 data,12 crc,13 gap3
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_reg <= S_IDLE;
      fld_reg <= 4'h0;
      cnt_reg <= 13'h0;
      crc_reg <= `FDTF_CRC_INIT;
      tick_reg <= 16'h0;
      mode_reg <= `FDTF_MODE_MFM;
      del_reg <= 1'b0;
      sc_reg <= 8'h0;
      gpl_reg <= 8'h0;
      fill_reg <= 8'h0;
      nsz_reg <= 8'h0;
      sect_reg <= 8'h0;
      chrn_reg <= 32'h0;
      chrn_ok_reg <= 1'b0;
      res_reg <= 32'h0;
      ic_reg <= `FDTF_IC_NORMAL;
      pend_ic_reg <= `FDTF_IC_NORMAL;
      se_reg <= 1'b0;
      pend_se_reg <= 1'b0;
      ma_reg <= 1'b0;
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      idx_seen_reg <= 2'h0;
      ist_reg <= 2'h0;
      imsk_reg <= 2'h0;
      wr_byte_o <= 8'h0;
      wr_strobe_o <= 1'b0;
      wr_mark_o <= 1'b0;
      wr_gate_o <= 1'b0;
      irq_o <= 1'b0;
      sect_evt_reg <= 1'b0;
      done_evt_reg <= 1'b0;
    end else begin
      sect_evt_reg <= 1'b0;
      done_evt_reg <= 1'b0;
      wr_strobe_o <= 1'b0;
      wr_mark_o <= 1'b0;  // Mark flag only stands with its strobe
      tick_reg <= tick ? BYTE_CYC[15:0] - 16'd1 : tick_reg - 16'd1;
      // Register writes; commands ignored while busy
      if (do_wr) begin
        case (aw_reg)
          `FDTF_OFF_CTRL: begin
            mode_reg <= w_reg[1:0];
            del_reg  <= w_reg[2];
          end
          `FDTF_OFF_FMT: begin
            nsz_reg  <= w_reg[7:0];
            sc_reg   <= w_reg[15:8];
            gpl_reg  <= w_reg[23:16];
            fill_reg <= w_reg[31:24];
          end
          `FDTF_OFF_CHRN: begin
            chrn_reg    <= w_reg;
            chrn_ok_reg <= 1'b1;
          end
          `FDTF_OFF_IRQ_MSK: imsk_reg <= w_reg[1:0];
          `FDTF_OFF_CMD: if (!busy_reg) begin
            case (w_reg[2:0])
              `FDTF_CMD_FORMAT: begin
                busy_reg <= 1'b1;
                st_reg   <= S_IDLE;
                fld_reg  <= 4'hf;  // Wait for index
                sect_reg <= 8'h0;
              end
              `FDTF_CMD_READID: begin
                busy_reg     <= 1'b1;
                st_reg       <= S_RID;
                idx_seen_reg <= 2'h0;
                ma_reg       <= 1'b0;
              end
              `FDTF_CMD_SENSE: begin
                ic_reg   <= pend_reg ? pend_ic_reg : `FDTF_IC_POLL;
                se_reg   <= pend_reg & pend_se_reg;
                pend_reg <= 1'b0;
              end
              `FDTF_CMD_SEEKEND, `FDTF_CMD_SEEKERR: begin
                pend_reg    <= 1'b1;
                pend_se_reg <= 1'b1;
                pend_ic_reg <= w_reg[0] ? `FDTF_IC_ABNORMAL
                                        : `FDTF_IC_NORMAL;
                done_evt_reg <= 1'b1;
              end
              default: ; // other controls: no interrupt
            endcase
          end
          default: ;
        endcase
      end
      // Read identifier search
      if (st_reg == S_RID) begin
        if (id_valid_i) begin
          res_reg     <= id_chrn_i;
          ic_reg      <= `FDTF_IC_NORMAL;
          pend_reg    <= 1'b1;
          done_evt_reg <= 1'b1;
          pend_se_reg <= 1'b0;
          pend_ic_reg <= `FDTF_IC_NORMAL;
          busy_reg    <= 1'b0;
          st_reg      <= S_IDLE;
        end else if (idx_pulse) begin
          if (idx_seen_reg == 2'h1) begin
            ic_reg      <= `FDTF_IC_ABNORMAL;
            ma_reg      <= 1'b1;
            pend_reg    <= 1'b1;
            done_evt_reg <= 1'b1;
            pend_se_reg <= 1'b0;
            pend_ic_reg <= `FDTF_IC_ABNORMAL;
            busy_reg    <= 1'b0;
            st_reg      <= S_IDLE;
          end
          idx_seen_reg <= idx_seen_reg + 2'h1;
        end
      end
      // Format: start at index, stop at next index
      if (busy_reg && st_reg != S_RID) begin
        if (fld_reg == 4'hf) begin
          if (idx_pulse) begin
            fld_reg   <= 4'h0;
            cnt_reg   <= 13'h0;
            wr_gate_o <= 1'b1;
          end
        end else if (idx_pulse || (fld_reg == 4'h4 && sect_reg == sc_reg
                                  && cnt_reg == 13'h0)) begin
          if (idx_pulse) begin
            wr_gate_o <= 1'b0;
            busy_reg  <= 1'b0;
            pend_reg  <= 1'b1;
            done_evt_reg <= 1'b1;
            pend_se_reg <= 1'b0;
            pend_ic_reg <= `FDTF_IC_NORMAL;
          end else if (tick) begin
            wr_byte_o   <= gapb(mfm);
            wr_mark_o   <= 1'b0;
            wr_strobe_o <= 1'b1;
          end
        end else if (tick) begin
          wr_strobe_o <= 1'b1;
          wr_mark_o   <= 1'b0;
          cnt_reg     <= cnt_reg + 13'd1;
          case (fld_reg)
            4'h0, 4'h3, 4'h8, 4'hd: begin
              wr_byte_o <= gapb(mfm);
              if (cnt_reg + 13'd1 == {5'h0,
                  fld_reg == 4'h0 ? (mfm ? `FDTF_MFM_GAP4A : `FDTF_FM_GAP4A) :
                  fld_reg == 4'h3 ? (mfm ? `FDTF_MFM_GAP1 : `FDTF_FM_GAP1) :
                  fld_reg == 4'h8 ? (!mfm ? `FDTF_FM_GAP2 :
                    mode_reg == `FDTF_MODE_PERP ? `FDTF_PERP_GAP2
                                                : `FDTF_MFM_GAP2) :
                  gpl_reg}) begin // gap3 from host gap length
                cnt_reg <= 13'h0;
                fld_reg <= (fld_reg == 4'hd) ? 4'h4 : fld_reg + 4'h1;
                if (fld_reg == 4'hd)
                  sect_reg <= sect_reg + 8'h1;
              end
            end
            4'h1, 4'h4, 4'h9: begin
              wr_byte_o <= 8'h00;
              crc_reg   <= `FDTF_CRC_INIT;
              if (cnt_reg + 13'd1 ==
                  {5'h0, mfm ? `FDTF_MFM_SYNC : `FDTF_FM_SYNC}) begin
                cnt_reg <= 13'h0;
                fld_reg <= fld_reg + 4'h1;
              end
            end
            4'h2, 4'h5, 4'ha: begin
              // prefix and mark bytes carry missing clocks, except the MFM data mark byte
              wr_mark_o <= mfm && cnt_reg < 13'd3 || fld_reg != 4'ha
                           || !mfm && cnt_reg == 13'h0;
              if (mfm && cnt_reg < 13'd3)
                wr_byte_o <= (fld_reg == 4'h2) ? 8'hc2 : 8'ha1;
              else
                wr_byte_o <= (fld_reg == 4'h2) ? 8'hfc :
                             (fld_reg == 4'h5) ? 8'hfe :
                             del_reg ? 8'hf8 : 8'hfb;
              // marks and prefixes enter the CRC
              crc_reg <= crc8(crc_reg, (mfm && cnt_reg < 13'd3) ?
                         8'ha1 : (fld_reg == 4'h5) ? 8'hfe :
                         del_reg ? 8'hf8 : 8'hfb);
              if (cnt_reg == (mfm ? 13'd3 : 13'd0)) begin
                cnt_reg <= 13'h0;
                fld_reg <= fld_reg + 4'h1;
              end
            end
            4'h6, 4'hb: begin
              wr_byte_o <= (fld_reg == 4'hb) ? fill_reg :
                           chrn_reg[31 - cnt_reg[1:0]*8 -: 8];
              crc_reg <= crc8(crc_reg, (fld_reg == 4'hb) ? fill_reg :
                         chrn_reg[31 - cnt_reg[1:0]*8 -: 8]);
              // sector length 128 << size code bits 2:0, at most 8192 in the 13-bit count
              if (cnt_reg + 13'd1 == ((fld_reg == 4'h6) ? 13'd4 :
                  (`FDTF_SECT_BASE << nsz_reg[2:0]))) begin
                cnt_reg <= 13'h0;
                fld_reg <= fld_reg + 4'h1;
                if (fld_reg == 4'h6) begin
                  chrn_ok_reg <= 1'b0;
                  sect_evt_reg <= 1'b1;
                end
              end
            end
            default: begin
              wr_byte_o <= cnt_reg[0] ? crc_reg[7:0] : crc_reg[15:8];
              if (cnt_reg[0]) begin
                cnt_reg <= 13'h0;
                fld_reg <= fld_reg + 4'h1;
              end
            end
          endcase
        end
      end
      // Sticky events: set wins over write-one clear
      ist_reg[`FDTF_IRQ_SECT] <= sect_evt_reg | (ist_reg[`FDTF_IRQ_SECT] &
        ~(do_wr && aw_reg == `FDTF_OFF_IRQ_ST && w_reg[`FDTF_IRQ_SECT]));
      ist_reg[`FDTF_IRQ_DONE] <= done_evt_reg | (ist_reg[`FDTF_IRQ_DONE] &
        ~(do_wr && aw_reg == `FDTF_OFF_IRQ_ST && w_reg[`FDTF_IRQ_DONE]));
      irq_o <= |(ist_reg & imsk_reg);
    end
  end
endmodule
`default_nettype wire

/* verif/fdtf_core_properties.sv */
// Purpose: port properties of the track format and control block
// Assumes: BYTE_CYC of 4, one clock, synchronous low reset
// Notes:   bound into fdtf_core below the module
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Checker
module fdtf_core_properties #(
  parameter BYTE_CYC = 4
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       index_pulse_in_n_i,
  input wire logic [7:0] wr_byte_o,
  input wire logic       wr_strobe_o,
  input wire logic       wr_mark_o,
  input wire logic       wr_gate_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic       idx_q;
  logic [3:0] idx_age;
  // Cycles since the last index fall; saturates so it never wraps
  always_ff @(posedge clk_sys_i) begin
    idx_q <= index_pulse_in_n_i;
    if (!rst_n_i) idx_age <= 4'hf;
    else if (idx_q && !index_pulse_in_n_i) idx_age <= 4'h0;
    else if (idx_age != 4'hf) idx_age <= idx_age + 4'h1;
  end
  // Spacing is written for BYTE_CYC of 4
  a_byte_spacing: assert property (wr_strobe_o |=> !wr_strobe_o [*3])
    else $error("write strobes closer than one byte time");
  a_strobe_gated: assert property (wr_strobe_o |-> wr_gate_o)
    else $error("byte strobe outside write gate");
  a_gate_start: assert property ($rose(wr_gate_o) |-> idx_age < 4'hc)
    else $error("write gate opened without an index pulse");
  a_gate_stop: assert property (wr_gate_o && $fell(index_pulse_in_n_i)
    |-> ##[1:12] !wr_gate_o) else $error("write gate kept past index");
  a_mark_strobed: assert property (wr_mark_o |-> wr_strobe_o)
    else $error("mark flag without strobe");
  a_mark_bytes: assert property (wr_mark_o |-> wr_byte_o inside
    {8'hc2, 8'ha1, 8'hfc, 8'hfe, 8'hfb, 8'hf8})
    else $error("mark flag on a plain byte");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  a_read_slverr: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h1c |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  c_format: cover property ($rose(wr_gate_o));
  c_irq: cover property ($rose(irq_o));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind fdtf_core fdtf_core_properties #(.BYTE_CYC(BYTE_CYC)) u_props (.*);
`default_nettype wire

/* verif/fdtf_drive_model.sv */
// Purpose: drive side: index pulses and identifier decoder output
// Assumes: requests arrive from the bench just after clock edges
// Notes:   idle id bus inverts each cycle so stale data never matches
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Drive model
module fdtf_drive_model (
  input  wire logic        clk_sys_i,
  input  wire logic        idx_req_i,
  input  wire logic        id_go_i,
  input  wire logic [31:0] id_val_i,
  output wire logic        idx_n_o,
  output var  logic        id_valid_o,
  output var  logic [31:0] id_chrn_o
);
  logic [3:0] low_cnt = 4'h0;
  initial id_valid_o = 1'b0;
  initial id_chrn_o = 32'h0;
  // Index pulse low for eight clocks per request
  always @(posedge clk_sys_i) begin
    if (idx_req_i) low_cnt <= 4'h8;
    else if (low_cnt != 4'h0) low_cnt <= low_cnt - 4'h1;
    id_valid_o <= id_go_i;
    id_chrn_o  <= id_go_i ? id_val_i : ~id_chrn_o;
  end
  assign idx_n_o = (low_cnt == 4'h0);
endmodule
`default_nettype wire

/* verif/fdtf_core_bench.sv */
// Purpose: self-checking bench for the track format block
// Assumes: BYTE_CYC of 4, one sector per track
// Notes:   byte stream and reads checked against queued notes
`timescale 1ns/10ps
`default_nettype none
`include "fdtf_defines.vh"
module fdtf_core_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        idx_req = 1'b0;
  logic        id_go = 1'b0;
  logic [31:0] id_val = 32'h0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic   s_axi_rvalid, wr_strobe_o, wr_mark_o, wr_gate_o, irq_o;
  wire logic   index_pulse_in_n_i, id_valid_i;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [7:0]  wr_byte_o;
  wire logic [31:0] s_axi_rdata, id_chrn_i;
  int          mismatches = 0;
  int          checks_done = 0;
  logic [9:0]  exp_q[$];
  logic [65:0] rd_q[$];
  logic [65:0] re;
  logic [9:0]  be;
  logic [31:0] rng = 32'he588a297;
  logic [31:0] f;
  logic [15:0] crc;
  fdtf_core #(.BYTE_CYC(4)) dut (.*);
  fdtf_drive_model drive (.clk_sys_i(clk_sys_i), .idx_req_i(idx_req),
    .id_go_i(id_go), .id_val_i(id_val), .idx_n_o(index_pulse_in_n_i),
    .id_valid_o(id_valid_i), .id_chrn_o(id_chrn_i));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("Error %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task give_verdict();
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] d);
    c ^= {d, 8'h00};
    repeat (8) c = c[15] ? (c << 1) ^ `FDTF_CRC_POLY : c << 1;
    return c;
  endfunction
  // Queue n bytes; mk is {check mark, mark}
  task automatic put(input int n, input logic [7:0] b, input logic [1:0] mk);
    repeat (n) begin
      exp_q.push_back({mk, b});
      crc = crc8(crc, b);
    end
  endtask
  task automatic put_crc();
    logic [15:0] c;
    c = crc;
    put(1, c[15:8], 2'b10);
    put(1, c[7:0], 2'b10);
  endtask
  // Whole expected track for one sector of size code n
  task automatic track(input logic [1:0] md, input logic dl,
    input logic [7:0] n, input logic [7:0] fl, input logic [7:0] gl,
    input logic [31:0] id);
    logic       fm;
    logic [7:0] g;
    fm = (md == `FDTF_MODE_FM);
    g = fm ? 8'hff : 8'h4e;
    put(fm ? 40 : 80, g, 2'b10);
    put(fm ? 6 : 12, 8'h00, 2'b10);
    if (!fm) put(3, 8'hc2, 2'b11);
    put(1, 8'hfc, 2'b00);
    put(fm ? 26 : 50, g, 2'b10);
    put(fm ? 6 : 12, 8'h00, 2'b10);
    crc = `FDTF_CRC_INIT;
    if (!fm) put(3, 8'ha1, 2'b11);
    put(1, 8'hfe, 2'b00);
    for (int i = 3; i >= 0; i--) put(1, id[8*i +: 8], 2'b10);
    put_crc();
    put(fm ? 11 : (md == `FDTF_MODE_PERP ? 41 : 22), g, 2'b10);
    put(fm ? 6 : 12, 8'h00, 2'b10);
    crc = `FDTF_CRC_INIT;
    if (!fm) put(3, 8'ha1, 2'b11);
    put(1, dl ? 8'hf8 : 8'hfb, 2'b00);
    put(128 << n, fl, 2'b10);
    put_crc();
    put(gl, g, 2'b10);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (!s_axi_bvalid && t < 200);
    s_axi_bready <= 1'b0;
    check({29'h0, s_axi_bvalid, s_axi_bresp}, 32'h4);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] v, input logic [1:0] r);
    int t;
    @(posedge clk_sys_i);
    rd_q.push_back({r, m, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (!s_axi_rvalid && t < 200);
    s_axi_rready <= 1'b0;
    check({31'h0, s_axi_rvalid}, 32'h1);
  endtask
  task automatic pulse(input logic is_id, input logic [31:0] v);
    @(posedge clk_sys_i);
    id_val <= v;
    if (is_id) id_go <= 1'b1;
    else idx_req <= 1'b1;
    @(posedge clk_sys_i);
    id_go <= 1'b0;
    idx_req <= 1'b0;
  endtask
  // ==========================================================
  // Monitor: oldest note against each result
  always @(posedge clk_sys_i) begin
    if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0) begin
      re = rd_q.pop_front();
      check(s_axi_rdata & re[63:32], re[31:0]);
      check({30'h0, s_axi_rresp}, {30'h0, re[65:64]});
    end
    if (wr_strobe_o && exp_q.size() > 0) begin
      be = exp_q.pop_front();
      check({24'h0, wr_byte_o}, {24'h0, be[7:0]});
      if (be[9]) check({31'h0, wr_mark_o}, {31'h0, be[8]});
    end
  end
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    int         t;
    logic [7:0] n;
    logic [7:0] gl;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    wr(`FDTF_OFF_IRQ_MSK, 32'h1);
    for (int md = 0; md < 3; md++) begin
      f = rnd();
      n = (md == 1) ? 8'h01 : 8'h00;
      gl = {5'h0, f[2:0]} + 8'h01;
      wr(`FDTF_OFF_CTRL, {29'h0, md == 1, md[1:0]});
      wr(`FDTF_OFF_FMT, {f[7:0], gl, 8'h01, n});
      wr(`FDTF_OFF_CHRN, {f[31:8], n});
      wr(`FDTF_OFF_CMD, {29'h0, `FDTF_CMD_FORMAT});
      repeat (20) @(posedge clk_sys_i);
      check({31'h0, wr_gate_o}, 32'h0);
      track(md[1:0], md == 1, n, f[7:0], gl, {f[31:8], n});
      pulse(1'b0, 32'h0);
      t = 0;
      while (exp_q.size() > 0 && t < 9000) begin
        @(posedge clk_sys_i);
        t++;
      end
      check(exp_q.size(), 32'h0);
      repeat (40) @(posedge clk_sys_i);
      pulse(1'b0, 32'h0);
      repeat (30) @(posedge clk_sys_i);
      check({30'h0, wr_gate_o, irq_o}, 32'h1);
      rd(`FDTF_OFF_IRQ_ST, 32'h3, 32'h3, 2'h0);
      wr(`FDTF_OFF_IRQ_ST, 32'hffffffff);
      exp_q.delete();
    end
    // Identifier read: first of two ids is kept
    f = rnd();
    wr(`FDTF_OFF_CMD, {29'h0, `FDTF_CMD_READID});
    pulse(1'b1, f);
    pulse(1'b1, ~f);
    repeat (10) @(posedge clk_sys_i);
    check({31'h0, irq_o}, 32'h1);
    rd(`FDTF_OFF_RESULT, 32'hffffffff, f, 2'h0);
    rd(`FDTF_OFF_STAT, 32'h13, 32'h0, 2'h0);
    // Identifier read with no mark until the second index
    wr(`FDTF_OFF_IRQ_ST, 32'hffffffff);
    wr(`FDTF_OFF_CMD, {29'h0, `FDTF_CMD_READID});
    pulse(1'b0, 32'h0);
    repeat (30) @(posedge clk_sys_i);
    rd(`FDTF_OFF_STAT, 32'h20, 32'h20, 2'h0);
    check({31'h0, irq_o}, 32'h0);
    pulse(1'b0, 32'h0);
    repeat (30) @(posedge clk_sys_i);
    rd(`FDTF_OFF_STAT, 32'h13, 32'h11, 2'h0);
    check({31'h0, irq_o}, 32'h1);
    wr(`FDTF_OFF_CMD, {29'h0, `FDTF_CMD_SENSE});
    // Seek completions, masked first, then sensed
    for (int k = 0; k < 2; k++) begin
      wr(`FDTF_OFF_IRQ_ST, 32'hffffffff);
      wr(`FDTF_OFF_IRQ_MSK, 32'h0);
      wr(`FDTF_OFF_CMD, {29'h0, k ? `FDTF_CMD_SEEKERR : `FDTF_CMD_SEEKEND});
      repeat (4) @(posedge clk_sys_i);
      check({31'h0, irq_o}, 32'h0);
      rd(`FDTF_OFF_IRQ_ST, 32'h1, 32'h1, 2'h0);
      wr(`FDTF_OFF_IRQ_MSK, 32'h1);
      repeat (3) @(posedge clk_sys_i);
      check({31'h0, irq_o}, 32'h1);
      wr(`FDTF_OFF_CMD, {29'h0, `FDTF_CMD_SENSE});
      rd(`FDTF_OFF_STAT, 32'h47, {29'h1, 1'b0, k == 1}, 2'h0);
    end
    wr(`FDTF_OFF_CMD, {29'h0, `FDTF_CMD_SENSE});
    rd(`FDTF_OFF_STAT, 32'h07, 32'h03, 2'h0);
    // Other control command: no interrupt; cleared status stays clear
    wr(`FDTF_OFF_IRQ_ST, 32'hffffffff);
    wr(`FDTF_OFF_CMD, {29'h0, `FDTF_CMD_OTHER});
    repeat (20) @(posedge clk_sys_i);
    check({31'h0, irq_o}, 32'h0);
    rd(`FDTF_OFF_IRQ_ST, 32'h1, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 32'h0, 2'h2);
    repeat (4) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule
`default_nettype wire
